// File: design/qcap_serial.sv
// Serial port of the four-input converter: shift-clock link side and system side.
`timescale 1ns/1ps
module qcap_serial
    import qcap_pkg::*;
(
    input wire logic clock,
    input wire logic resetn,
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic din,
    output logic dout,
    output logic dout_oe,
    input wire logic [RES_BITS-1:0] analog_input_1,
    input wire logic [RES_BITS-1:0] analog_input_2,
    input wire logic [RES_BITS-1:0] analog_input_3,
    input wire logic [RES_BITS-1:0] analog_input_4,
    output logic [CHAN_BITS-1:0] conv_chan,
    output logic overrun
);

    // ==========================================================
    // Link side declarations
    logic frame_rst_n;
    logic [3:0] bit_cnt_q;
    logic [CTRL_BITS-1:0] ctl_shift_q;
    logic [CTRL_BITS-1:0] ctl_next;
    logic [CHAN_BITS-1:0] chan_q;
    logic req_tgl_q;
    logic [CHAN_BITS-1:0] req_chan_q;
    logic [FRAME_BITS-1:0] frame_word_q;
    logic dout_q;
    logic dout_oe_q;
    logic [SYNC_STAGES-1:0] hand_sync_q;
    logic hand_seen_q;
    logic [RES_BITS-1:0] rx_word_q;
    logic hand_event;

    // ==========================================================
    // System side declarations
    logic [SYNC_STAGES-1:0] req_sync_q;
    logic req_seen_q;
    logic req_event;
    qcap_samp_state_type samp_state_q;
    logic [RES_BITS-1:0] sample_q;
    logic [RES_BITS-1:0] sel_value;
    logic [RES_BITS-1:0] chan_value [NUM_CHAN];
    logic [CHAN_BITS-1:0] conv_chan_q;
    logic overrun_q;
    logic push_valid;
    logic push_ready;
    logic pop_valid;
    logic pop_ready;
    logic [RES_BITS-1:0] pop_data;
    qcap_hand_state_type hand_state_q;
    logic hand_tgl_q;
    logic [RES_BITS-1:0] hand_word_q;
    logic [SYNC_STAGES-1:0] ack_sync_q;
    logic ack_agreed;
    logic [SYNC_STAGES-1:0] sys_rst_q;
    logic sys_rst_n;

    // ==========================================================
    // Frame counter
    // Chip select high holds the frame logic in reset, so its fall starts a
    // fresh frame and no edge of a stopped shift clock is ever needed.
    assign frame_rst_n = resetn & ~cs_n;

    always_ff @(posedge sclk or negedge frame_rst_n) begin
        if (!frame_rst_n) begin
            bit_cnt_q <= FRAME_FIRST;
        end else begin
            bit_cnt_q <= bit_cnt_q + 4'h1;
        end
    end

    // ==========================================================
    // Control register load
    assign ctl_next = {ctl_shift_q[CTRL_BITS-2:0], din};

    always_ff @(posedge sclk or negedge frame_rst_n) begin
        if (!frame_rst_n) begin
            ctl_shift_q <= '0;
        end else begin
            ctl_shift_q <= ctl_next;
        end
    end

    // The channel survives chip select going high; only a real reset clears it.
    always_ff @(posedge sclk or negedge resetn) begin
        if (!resetn) begin
            chan_q <= CHAN_RESET;
        end else if (bit_cnt_q == CTRL_LAST) begin
            chan_q <= ctl_next[CHAN_MSB:CHAN_LSB];
        end
    end

    // ==========================================================
    // Conversion request
    // Each frame's first rising edge asks for one conversion with the channel
    // loaded in an earlier frame; the channel word is held for a whole frame
    // so the system side may read it once the toggle has crossed.
    always_ff @(posedge sclk or negedge resetn) begin
        if (!resetn) begin
            req_tgl_q <= 1'b0;
            req_chan_q <= CHAN_RESET;
        end else if (!cs_n && bit_cnt_q == FRAME_FIRST) begin
            req_tgl_q <= ~req_tgl_q;
            req_chan_q <= chan_q;
        end
    end

    // ==========================================================
    // Result framing
    always_ff @(posedge sclk or negedge resetn) begin
        if (!resetn) begin
            frame_word_q <= FRAME_RESET;
        end else if (bit_cnt_q == FRAME_FIRST) begin
            frame_word_q <= {{LEAD_PAD{1'b0}}, rx_word_q, {TRAIL_PAD{1'b0}}};
        end
    end

    always_ff @(negedge sclk or negedge frame_rst_n) begin
        if (!frame_rst_n) begin
            dout_q <= 1'b0;
            dout_oe_q <= 1'b0;
        end else begin
            dout_q <= frame_word_q[FRAME_LAST - bit_cnt_q];
            dout_oe_q <= 1'b1;
        end
    end

    assign dout = dout_q;
    assign dout_oe = dout_oe_q;

    // ==========================================================
    // Result word arrival on the link side
    assign hand_event = (hand_sync_q[1] == hand_sync_q[2]) && (hand_sync_q[2] != hand_seen_q);

    always_ff @(posedge sclk or negedge resetn) begin
        if (!resetn) begin
            hand_sync_q <= '0;
        end else begin
            hand_sync_q <= {hand_sync_q[SYNC_STAGES-2:0], hand_tgl_q};
        end
    end

    always_ff @(posedge sclk or negedge resetn) begin
        if (!resetn) begin
            hand_seen_q <= 1'b0;
            rx_word_q <= RESULT_RESET;
        end else if (hand_event) begin
            hand_seen_q <= hand_sync_q[2];
            rx_word_q <= hand_word_q;
        end
    end

    // ==========================================================
    // System reset release
    // Reset takes the system side at once but lets go only in step with the
    // clock, so no flop there sees its release close to an edge.
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            sys_rst_q <= '0;
        end else begin
            sys_rst_q <= {sys_rst_q[SYNC_STAGES-2:0], 1'b1};
        end
    end

    assign sys_rst_n = sys_rst_q[1] & sys_rst_q[2];

    // ==========================================================
    // Request arrival on the system side
    assign req_event = (req_sync_q[1] == req_sync_q[2]) && (req_sync_q[2] != req_seen_q);

    always_ff @(posedge clock or negedge sys_rst_n) begin
        if (!sys_rst_n) begin
            req_sync_q <= '0;
        end else begin
            req_sync_q <= {req_sync_q[SYNC_STAGES-2:0], req_tgl_q};
        end
    end

    always_ff @(posedge clock or negedge sys_rst_n) begin
        if (!sys_rst_n) begin
            req_seen_q <= 1'b0;
        end else if (req_event) begin
            req_seen_q <= req_sync_q[2];
        end
    end

    // ==========================================================
    // Channel selection and sampling
    assign chan_value[0] = analog_input_1;
    assign chan_value[1] = analog_input_2;
    assign chan_value[2] = analog_input_3;
    assign chan_value[3] = analog_input_4;
    assign sel_value = chan_value[req_chan_q];

    always_ff @(posedge clock or negedge sys_rst_n) begin
        if (!sys_rst_n) begin
            samp_state_q <= SAMP_IDLE;
        end else begin
            unique case (samp_state_q)
                SAMP_IDLE: begin
                    if (req_event) begin
                        samp_state_q <= SAMP_PUSH;
                    end
                end
                SAMP_PUSH: begin
                    if (push_ready) begin
                        samp_state_q <= SAMP_IDLE;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clock or negedge sys_rst_n) begin
        if (!sys_rst_n) begin
            sample_q <= RESULT_RESET;
            conv_chan_q <= CHAN_RESET;
        end else if (req_event && samp_state_q == SAMP_IDLE) begin
            sample_q <= sel_value;
            conv_chan_q <= req_chan_q;
        end
    end

    // A request that lands while the last result still waits for FIFO room is
    // dropped; the sticky flag lets the system see that readout fell behind.
    always_ff @(posedge clock or negedge sys_rst_n) begin
        if (!sys_rst_n) begin
            overrun_q <= 1'b0;
        end else if (req_event && samp_state_q == SAMP_PUSH) begin
            overrun_q <= 1'b1;
        end
    end

    assign push_valid = (samp_state_q == SAMP_PUSH);
    assign conv_chan = conv_chan_q;
    assign overrun = overrun_q;

    // ==========================================================
    // Result buffer
    qcap_fifo #(
        .WIDTH(RES_BITS),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clock(clock),
        .resetn(sys_rst_n),
        .in_valid(push_valid),
        .in_ready(push_ready),
        .in_data(sample_q),
        .out_valid(pop_valid),
        .out_ready(pop_ready),
        .out_data(pop_data)
    );

    // ==========================================================
    // Result hand-off toward the link side
    // The word is held until the link side acknowledges it, so no bit of it
    // changes while the slow shift clock may capture it.
    assign pop_ready = (hand_state_q == HAND_IDLE);
    assign ack_agreed = (ack_sync_q[1] == ack_sync_q[2]) && (ack_sync_q[2] == hand_tgl_q);

    always_ff @(posedge clock or negedge sys_rst_n) begin
        if (!sys_rst_n) begin
            ack_sync_q <= '0;
        end else begin
            ack_sync_q <= {ack_sync_q[SYNC_STAGES-2:0], hand_seen_q};
        end
    end

    always_ff @(posedge clock or negedge sys_rst_n) begin
        if (!sys_rst_n) begin
            hand_state_q <= HAND_IDLE;
            hand_tgl_q <= 1'b0;
            hand_word_q <= RESULT_RESET;
        end else begin
            unique case (hand_state_q)
                HAND_IDLE: begin
                    if (pop_valid) begin
                        hand_word_q <= pop_data;
                        hand_tgl_q <= ~hand_tgl_q;
                        hand_state_q <= HAND_WAIT;
                    end
                end
                HAND_WAIT: begin
                    if (ack_agreed) begin
                        hand_state_q <= HAND_IDLE;
                    end
                end
            endcase
        end
    end

endmodule // qcap_serial

// File: design/qcap_pkg.sv
// Constants and types shared by the four-input converter serial port.
// Contract
// - A conversion process starts when chip select falls from high to low; here the request goes out on the first shift clock rise after the fall.
// - Conversions repeat back to back while chip select stays low.
// - The shift clock alone paces conversion steps and result readout; here the system clock paces sampling, FIFO buffering and hand-off.
// - Each result bit leaves the data output on a shift clock falling edge.
// - Data input bits enter the control register on shift clock rising edges.
// - Each result is a 10-bit unsigned straight binary value.
// - The control register selects which of four inputs is converted.
package qcap_pkg;

    // ==========================================================
    // Frame format
    localparam int RES_BITS = 10;
    localparam int FRAME_BITS = 16;
    localparam int LEAD_PAD = 4;
    localparam int TRAIL_PAD = FRAME_BITS - LEAD_PAD - RES_BITS;
    localparam int CTRL_BITS = 8;
    localparam int CHAN_MSB = 4;
    localparam int CHAN_LSB = 3;
    localparam int CHAN_BITS = CHAN_MSB - CHAN_LSB + 1;
    localparam int NUM_CHAN = 4;
    localparam logic [3:0] FRAME_FIRST = 4'h0;
    localparam logic [3:0] FRAME_LAST = 4'hf;
    localparam logic [3:0] CTRL_LAST = 4'h7;

    // ==========================================================
    // Reset values and structure
    localparam logic [CHAN_BITS-1:0] CHAN_RESET = 2'h0;
    localparam logic [RES_BITS-1:0] RESULT_RESET = 10'h000;
    localparam logic [FRAME_BITS-1:0] FRAME_RESET = 16'h0000;
    localparam int FIFO_DEPTH = 4;
    localparam int SYNC_STAGES = 3;

    // ==========================================================
    // State machines
    typedef enum logic [0:0] {
        SAMP_IDLE,
        SAMP_PUSH
    } qcap_samp_state_type;

    typedef enum logic [0:0] {
        HAND_IDLE,
        HAND_WAIT
    } qcap_hand_state_type;

endpackage

// File: design/qcap_fifo.sv
// Small flip-flop FIFO with valid and ready on both sides.
`timescale 1ns/1ps
module qcap_fifo #(
    parameter int WIDTH = 10,
    parameter int DEPTH = 4
) (
    input wire logic clock,
    input wire logic resetn,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);

    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam logic [AW:0] FULL_COUNT = (AW+1)'(DEPTH);
    localparam logic [AW-1:0] LAST_SLOT = AW'(DEPTH - 1);

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0] wr_q;
    logic [AW-1:0] rd_q;
    logic [AW:0] count_q;
    logic do_push;
    logic do_pop;

    assign in_ready = (count_q != FULL_COUNT);
    assign out_valid = (count_q != '0);
    assign out_data = mem_q[rd_q];
    assign do_push = in_valid && in_ready;
    assign do_pop = out_valid && out_ready;

    // ==========================================================
    // Storage
    always_ff @(posedge clock) begin
        if (do_push) begin
            mem_q[wr_q] <= in_data;
        end
    end

    // ==========================================================
    // Pointers and fill level
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            wr_q <= '0;
            rd_q <= '0;
            count_q <= '0;
        end else begin
            if (do_push) begin
                wr_q <= (wr_q == LAST_SLOT) ? '0 : wr_q + 1'b1;
            end
            if (do_pop) begin
                rd_q <= (rd_q == LAST_SLOT) ? '0 : rd_q + 1'b1;
            end
            if (do_push && !do_pop) begin
                count_q <= count_q + 1'b1;
            end else if (do_pop && !do_push) begin
                count_q <= count_q - 1'b1;
            end
        end
    end

endmodule // qcap_fifo

// File: dv/qcap_serial_asserts.sv
// Concurrent checks on the converter serial port pins.
`timescale 1ns/1ps
module qcap_serial_chk
    import qcap_pkg::*;
(
    input wire logic clock,
    input wire logic resetn,
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic dout,
    input wire logic dout_oe,
    input wire logic [CHAN_BITS-1:0] conv_chan
);
    // ==========================================================
    // Helpers
    logic [3:0] bit_cnt_q;
    logic [2:0] sync_q;
    logic [3:0] idle_q;
    // Rises seen in a frame; wraps as back-to-back frames do.
    always_ff @(posedge sclk or posedge cs_n) begin
        if (cs_n) bit_cnt_q <= 4'h0;
        else bit_cnt_q <= bit_cnt_q + 4'h1;
    end
    // Saturates, because the link clock stops between frames.
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            sync_q <= 3'h0;
            idle_q <= 4'hf;
        end else begin
            sync_q <= {sync_q[1:0], sclk};
            if (sync_q[2] != sync_q[1]) idle_q <= 4'h0;
            else if (idle_q != 4'hf) idle_q <= idle_q + 4'h1;
        end
    end
    // ==========================================================
    // Assertions
    sequence step_s;
        !cs_n ##1 !cs_n;
    endsequence
    chk_idle_quiet: assert property (@(posedge clock) disable iff (!resetn)
        cs_n && $past(cs_n) |-> !dout && !dout_oe) else $error("active while idle");
    chk_select_start: assert property (@(posedge clock) disable iff (!resetn)
        $fell(cs_n) |-> !dout && !dout_oe) else $error("active at select");
    chk_oe_in_frame: assert property (@(posedge sclk) disable iff (!resetn || cs_n)
        step_s ##0 (bit_cnt_q != 4'h0) |-> dout_oe) else $error("not enabled in frame");
    chk_lead_zero: assert property (@(posedge sclk) disable iff (!resetn || cs_n)
        bit_cnt_q < 4'h4 |-> !dout) else $error("lead pad not zero");
    chk_trail_zero: assert property (@(posedge sclk) disable iff (!resetn || cs_n)
        bit_cnt_q > 4'hd |-> !dout) else $error("trail pad not zero");
    chk_dout_fall_edge: assert property (@(posedge clock) disable iff (!resetn)
        !cs_n && $rose(sclk) |-> $stable(dout)) else $error("data moved on rise");
    chk_chan_in_frame: assert property (@(posedge clock) disable iff (!resetn)
        $changed(conv_chan) |-> !cs_n) else $error("conversion unselected");
    chk_chan_paced: assert property (@(posedge clock) disable iff (!resetn)
        $changed(conv_chan) |-> idle_q < 4'h8) else $error("conversion unpaced");
endmodule // qcap_serial_chk
bind qcap_serial qcap_serial_chk u_qcap_serial_chk (.clock(clock), .resetn(resetn),
    .sclk(sclk), .cs_n(cs_n), .dout(dout), .dout_oe(dout_oe), .conv_chan(conv_chan));

// File: dv/qcap_master.sv
// Serial master model that clocks frames through the converter port.
`timescale 1ns/1ps
module qcap_master (
    output logic sclk,
    output logic cs_n,
    output logic din,
    input wire logic dout
);
    // ==========================================================
    // Frame driver
    initial begin
        sclk = 1'b0;
        cs_n = 1'b1;
        din = 1'b0;
    end
    // The clock stands still between frames; a released din is inverted.
    task automatic run_frame(input logic [7:0] ctrl, input int nrise, input logic hold,
                             output logic [15:0] word);
        word = 16'h0000;
        if (cs_n) begin
            #5;
            cs_n = 1'b0;
        end
        for (int k = 0; k < nrise; k++) begin
            #8;
            din = (k < 8) ? ctrl[7-k] : ~din;
            #8;
            sclk = 1'b1;
            word = {word[14:0], dout};
            #16;
            sclk = 1'b0;
        end
        if (!hold) begin
            #16;
            cs_n = 1'b1;
            din = ~din;
        end
    endtask
endmodule // qcap_master

// File: dv/test_quad_channel_adc_serial_port.sv
// Self-checking bench for the converter serial port.
`timescale 1ns/1ps
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin miscompares++; \
    $display("CHECK FAILED %s expected %h seen %h", nm, e, g); end end
module test_quad_channel_adc_serial_port import qcap_pkg::*;;
    logic clock;
    logic resetn;
    logic sclk;
    logic cs_n;
    logic din;
    logic dout;
    logic dout_oe;
    logic overrun;
    logic [CHAN_BITS-1:0] conv_chan;
    logic [RES_BITS-1:0] ain [NUM_CHAN];
    logic [15:0] w;
    int miscompares = 0;
    int cmp_count = 0;
    qcap_serial u_qcap_serial (.clock(clock), .resetn(resetn), .sclk(sclk), .cs_n(cs_n),
        .din(din), .dout(dout), .dout_oe(dout_oe), .analog_input_1(ain[0]),
        .analog_input_2(ain[1]), .analog_input_3(ain[2]), .analog_input_4(ain[3]),
        .conv_chan(conv_chan), .overrun(overrun));
    qcap_master u_qcap_master (.sclk(sclk), .cs_n(cs_n), .din(din), .dout(dout));
    always #4 clock = ~clock;
    // ==========================================================
    // Tasks
    task automatic wrap_up();
        $display("compares %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task automatic frame(input logic [7:0] ctrl, input logic hold);
        u_qcap_master.run_frame(ctrl, 16, hold, w);
    endtask
    function automatic logic [15:0] word_of(input int c);
        return {4'h0, ain[c], 2'h0};
    endfunction
    task automatic check_reset();
        `CHK("dout_oe", 1'b0, dout_oe)
        `CHK("conv_chan", 2'h0, conv_chan)
        `CHK("overrun", 1'b0, overrun)
    endtask
    // Results lag two frames, so each channel needs three frames to show.
    task automatic chan_sweep();
        frame(8'h00, 1'b1);
        `CHK("first_word", 16'h0000, w)
        for (int c = 0; c < NUM_CHAN; c++) begin
            repeat (3) frame({3'h0, c[1:0], 3'h0}, 1'b1);
            `CHK("sweep_word", word_of(c), w)
            `CHK("sweep_chan", c[1:0], conv_chan)
        end
        frame(8'h18, 1'b0);
    endtask
    task automatic partial_frame();
        u_qcap_master.run_frame(8'h00, 6, 1'b0, w);
        frame(8'h18, 1'b0);
        frame(8'h18, 1'b0);
        `CHK("partial_word", word_of(3), w)
        `CHK("partial_chan", 2'h3, conv_chan)
    endtask
    task automatic next_conv();
        frame(8'h00, 1'b1);
        frame(8'h00, 1'b1);
        `CHK("delay_word", word_of(3), w)
        frame(8'h00, 1'b0);
        `CHK("new_word", word_of(0), w)
        `CHK("overrun_end", 1'b0, overrun)
    endtask
    // One-edge frames ask faster than results drain, so the buffer must overflow.
    task automatic overrun_burst();
        repeat (12) u_qcap_master.run_frame(8'h00, 1, 1'b0, w);
        `CHK("overrun_set", 1'b1, overrun)
    endtask
    // ==========================================================
    // Main sequence
    initial begin
        clock = 1'b0;
        resetn = 1'b0;
        ain[0] = 10'h2a5;
        ain[1] = 10'h15a;
        ain[2] = 10'h3ff;
        ain[3] = 10'h001;
        repeat (16) @(posedge clock);
        @(negedge clock);
        resetn = 1'b1;
        repeat (4) @(negedge clock);
        check_reset();
        chan_sweep();
        partial_frame();
        next_conv();
        overrun_burst();
        wrap_up();
    end
    initial begin
        #300000;
        miscompares++;
        wrap_up();
    end
endmodule // test_quad_channel_adc_serial_port
